//--- design/ccr_pkg.sv
// Package with offsets, fields, keys and reset values for the CPU control register bank
package ccr_pkg;
	// ------------------------------------------------------------
	// Register indices, byte address is four times the index
	// ------------------------------------------------------------
	localparam logic [3:0] CCR_IDX_GUARD = 4'h4;
	localparam logic [3:0] CCR_IDX_SP_LO = 4'hd;
	localparam logic [3:0] CCR_IDX_SP_HI = 4'he;
	localparam logic [3:0] CCR_IDX_FLAGS = 4'hf;
	localparam int         CCR_ADDR_W    = 6;

	// ------------------------------------------------------------
	// Guard keys and fields
	// ------------------------------------------------------------
	localparam logic [7:0] CCR_SELF_PROGRAM_KEY = 8'h9d;
	localparam logic [7:0] CCR_IO_UNLOCK_KEY    = 8'hd8;
	localparam int         CCR_GUARD_IO_BIT     = 0;
	localparam int         CCR_GUARD_SPM_BIT    = 1;
	localparam logic [7:0] CCR_GUARD_RESET      = 8'h00;
	localparam logic [2:0] CCR_WINDOW_INSTR     = 3'h4;

	// ------------------------------------------------------------
	// Flags fields
	// ------------------------------------------------------------
	localparam int         CCR_FLAG_I     = 7;
	localparam int         CCR_FLAG_T     = 6;
	localparam int         CCR_FLAG_H     = 5;
	localparam int         CCR_FLAG_S     = 4;
	localparam int         CCR_FLAG_V     = 3;
	localparam int         CCR_FLAG_N     = 2;
	localparam int         CCR_FLAG_Z     = 1;
	localparam int         CCR_FLAG_C     = 0;
	localparam logic [7:0] CCR_FLAGS_RESET = 8'h00;

	// ------------------------------------------------------------
	// Stack defaults
	// ------------------------------------------------------------
	localparam int          CCR_SP_BITS    = 16;
	localparam logic [15:0] CCR_SRAM_TOP   = 16'h3fff;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic h;
		logic v;
		logic n;
		logic z;
		logic c;
	} ccr_alu_flags_t;

	typedef struct packed {
		logic io_open;
		logic spm_open;
		logic irq_allow;
	} ccr_status_t;
endpackage

//--- design/ccr_top.sv
// CPU control registers: unlock guard, stack pointer and processor flags
`timescale 1ns/1ps
`default_nettype none
module ccr_top
	import ccr_pkg::*;
#(
	parameter int          SP_BITS  = CCR_SP_BITS,
	parameter logic [15:0] SRAM_TOP = CCR_SRAM_TOP
)
(
	// Clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  arst_n,
	// Avalon-MM slave
	input  wire logic [CCR_ADDR_W-1:0] avs_address,
	input  wire logic                  avs_read,
	input  wire logic                  avs_write,
	input  wire logic [31:0]           avs_writedata,
	input  wire logic [3:0]            avs_byteenable,
	output logic      [31:0]           avs_readdata,
	output logic                       avs_waitrequest,
	// Instruction execution side
	input  wire logic                  instr_retired,
	input  wire logic                  mem_write,
	input  wire logic                  nvm_access,
	input  wire logic                  sleep_exec,
	input  wire logic                  gie_set,
	input  wire logic                  gie_clr,
	input  wire logic                  alu_we,
	input  wire ccr_alu_flags_t        alu_flags,
	input  wire logic                  bit_store_we,
	input  wire logic                  bit_store_val,
	input  wire logic                  sp_cpu_we,
	input  wire logic [15:0]           sp_cpu_val,
	// Core outputs
	output logic      [15:0]           stack_ptr,
	output logic      [7:0]            flags,
	output ccr_status_t                status
);

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	logic       word_ok;
	logic [3:0] idx;
	logic       lane0;
	logic       wr_guard;
	logic       wr_sp_lo;
	logic       wr_sp_hi;
	logic       wr_flags;
	logic       rd_sp_lo;
	logic       acc_ok;
	logic       gie_change;
	logic       wait_r;
	logic       other_io_wr;
	logic [7:0] flags_r;

	assign word_ok = (avs_address[1:0] == 2'b00);
	assign idx     = avs_address[5:2];
	assign lane0   = avs_byteenable[0];

	always_comb
	begin
		gie_change = avs_write && word_ok && lane0 && (idx == CCR_IDX_FLAGS)
			&& (avs_writedata[CCR_FLAG_I] != flags_r[CCR_FLAG_I]);
	end

	// Reads take one wait so read data comes from a flop
	assign avs_waitrequest = (avs_read || gie_change) && !wait_r;

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			wait_r <= 1'b0;
		else
			wait_r <= (avs_read || gie_change) && !wait_r;
	end

	assign acc_ok   = !avs_waitrequest && word_ok;
	assign wr_guard = avs_write && acc_ok && lane0 && (idx == CCR_IDX_GUARD);
	assign wr_sp_lo = avs_write && acc_ok && lane0 && (idx == CCR_IDX_SP_LO);
	assign wr_sp_hi = avs_write && acc_ok && lane0 && (idx == CCR_IDX_SP_HI);
	assign wr_flags = avs_write && acc_ok && lane0 && (idx == CCR_IDX_FLAGS);
	assign rd_sp_lo = avs_read && acc_ok && (idx == CCR_IDX_SP_LO);

	// Any write other than a guard register write counts as an I/O write
	assign other_io_wr = mem_write || (avs_write && !avs_waitrequest && !wr_guard);

	// ------------------------------------------------------------
	// Unlock window
	// ------------------------------------------------------------
	logic [2:0] win_cnt_r;
	logic       win_io_r;
	logic       win_spm_r;
	logic       key_io;
	logic       key_spm;
	logic       win_close;

	assign key_io    = wr_guard && (avs_writedata[7:0] == CCR_IO_UNLOCK_KEY);
	assign key_spm   = wr_guard && (avs_writedata[7:0] == CCR_SELF_PROGRAM_KEY);
	// Self-program window survives plain data writes, only NVM, sleep, a guard write or expiry end it
	assign win_close = nvm_access || sleep_exec;

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			win_cnt_r <= 3'h0;
		else if (key_io || key_spm)
			win_cnt_r <= CCR_WINDOW_INSTR;
		else if (win_close || (win_io_r && other_io_wr))
			win_cnt_r <= 3'h0;
		else if (instr_retired && (win_cnt_r != 3'h0))
			win_cnt_r <= win_cnt_r - 3'h1;
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			win_io_r  <= 1'b0;
			win_spm_r <= 1'b0;
		end
		else if (wr_guard)
		begin
			win_io_r  <= key_io;
			win_spm_r <= key_spm;
		end
		else if (win_close || (win_io_r && other_io_wr)
			|| (instr_retired && (win_cnt_r == 3'h1)) || (win_cnt_r == 3'h0))
		begin
			win_io_r  <= 1'b0;
			win_spm_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Stack pointer with temporary byte
	// ------------------------------------------------------------
	logic [15:0] sp_r;
	logic [7:0]  temp_r;
	logic [2:0]  sp_mask_r;

	// Constant so the reset branch loads a fixed value
	localparam logic [15:0] sp_mask = (SP_BITS >= 16) ? 16'hffff
		: 16'((17'h1 << SP_BITS) - 17'h1);

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			sp_r <= SRAM_TOP & sp_mask;
		else if (wr_sp_hi)
			sp_r <= {avs_writedata[7:0], temp_r} & sp_mask;
		else if (sp_cpu_we)
			sp_r <= sp_cpu_val & sp_mask;
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			temp_r <= 8'h00;
		else if (wr_sp_lo)
			temp_r <= avs_writedata[7:0];
		else if (rd_sp_lo)
			temp_r <= sp_r[15:8];
	end

	// Guards a two-byte stack update against an interrupt in between
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			sp_mask_r <= 3'h0;
		else if (wr_sp_lo)
			sp_mask_r <= CCR_WINDOW_INSTR;
		else if (other_io_wr)
			sp_mask_r <= 3'h0;
		else if (instr_retired && (sp_mask_r != 3'h0))
			sp_mask_r <= sp_mask_r - 3'h1;
	end

	// ------------------------------------------------------------
	// Processor flags
	// ------------------------------------------------------------
	logic [7:0] flags_nxt;

	always_comb
	begin
		flags_nxt = flags_r;
		if (gie_set)
			flags_nxt[CCR_FLAG_I] = 1'b1;
		if (gie_clr)
			flags_nxt[CCR_FLAG_I] = 1'b0;
		if (bit_store_we)
			flags_nxt[CCR_FLAG_T] = bit_store_val;
		if (alu_we)
		begin
			flags_nxt[CCR_FLAG_H] = alu_flags.h;
			flags_nxt[CCR_FLAG_V] = alu_flags.v;
			flags_nxt[CCR_FLAG_N] = alu_flags.n;
			flags_nxt[CCR_FLAG_Z] = alu_flags.z;
			flags_nxt[CCR_FLAG_C] = alu_flags.c;
		end
		if (wr_flags)
			flags_nxt = avs_writedata[7:0];
		// Sign is never stored on its own
		flags_nxt[CCR_FLAG_S] = flags_nxt[CCR_FLAG_N] ^ flags_nxt[CCR_FLAG_V];
	end

	// No interrupt-entry input exists, so only gie_clr or a bus write clears the enable
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			flags_r <= CCR_FLAGS_RESET;
		else
			flags_r <= flags_nxt;
	end

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	logic [7:0] guard_rd;
	logic [7:0] rd_mux;

	always_comb
	begin
		guard_rd = 8'h00;
		guard_rd[CCR_GUARD_IO_BIT]  = win_io_r;
		guard_rd[CCR_GUARD_SPM_BIT] = win_spm_r;
	end

	always_comb
	begin
		rd_mux = 8'h00;
		if (word_ok)
		begin
			case (idx)
				CCR_IDX_GUARD: rd_mux = guard_rd;
				CCR_IDX_SP_LO: rd_mux = sp_r[7:0];
				CCR_IDX_SP_HI: rd_mux = temp_r;
				CCR_IDX_FLAGS: rd_mux = flags_r;
				default:       rd_mux = 8'h00;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			avs_readdata <= 32'h0000_0000;
		else if (avs_read && !wait_r)
			avs_readdata <= {24'h00_0000, rd_mux};
	end

	// ------------------------------------------------------------
	// Core outputs
	// ------------------------------------------------------------
	assign stack_ptr = sp_r;
	assign flags     = flags_r;

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			status <= '0;
		else
		begin
			status.io_open   <= win_io_r;
			status.spm_open  <= win_spm_r;
			// Requests stay pending in the controller while held off
			status.irq_allow <= flags_nxt[CCR_FLAG_I] && !(key_io || key_spm)
				&& (win_cnt_r == 3'h0 || !(win_io_r || win_spm_r)) && !wr_sp_lo
				&& (sp_mask_r == 3'h0);
		end
	end

endmodule
`default_nettype wire

//--- dv/ccr_checker_assertions.sv
// Port checker of the control register bank
`timescale 1ns/1ps
`default_nettype none
module ccr_checker
	import ccr_pkg::*;
(
	// Clock and reset
	input wire logic                  sys_clk,
	input wire logic                  arst_n,
	// Bus
	input wire logic [CCR_ADDR_W-1:0] avs_address,
	input wire logic                  avs_write,
	input wire logic [31:0]           avs_writedata,
	input wire logic [3:0]            avs_byteenable,
	input wire logic                  avs_waitrequest,
	// Core side
	input wire logic                  gie_clr,
	input wire logic                  sp_cpu_we,
	input wire logic [15:0]           stack_ptr,
	input wire logic [7:0]            flags,
	input wire ccr_status_t           status
);
	logic gwr;
	// Guard write taken at this edge
	assign gwr = avs_write && !avs_waitrequest && avs_address == 6'h10 && avs_byteenable[0];
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!arst_n);
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_sign_follow: assert property (flags[4] == (flags[2] ^ flags[3]))
		else $error("sign flag wrong");
	a_gie_wait: assert property ($rose(avs_write) && avs_address == 6'h3c
		&& avs_byteenable[0] && avs_writedata[7] != flags[7]
		|-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("no wait on enable change");
	a_gie_kept: assert property ($fell(flags[7]) |-> $past(gie_clr) || $past(avs_write))
		else $error("enable cleared by itself");
	a_irq_block: assert property (!flags[7] |-> !status.irq_allow)
		else $error("irq allowed while disabled");
	a_window_irq: assert property (status.io_open || status.spm_open |-> !status.irq_allow)
		else $error("irq allowed in window");
	a_io_open: assert property (gwr && avs_writedata[7:0] == CCR_IO_UNLOCK_KEY
		|=> ##1 status.io_open)
		else $error("io window not open");
	a_spm_open: assert property (gwr && avs_writedata[7:0] == CCR_SELF_PROGRAM_KEY
		|=> ##1 status.spm_open)
		else $error("program window not open");
	a_sp_hold: assert property ($changed(stack_ptr) |-> $past(sp_cpu_we)
		|| $past(avs_write) && $past(avs_address) == 6'h38)
		else $error("stack moved unasked");
endmodule
bind ccr_top ccr_checker u_chk (.sys_clk, .arst_n, .avs_address, .avs_write, .avs_writedata,
	.avs_byteenable, .avs_waitrequest, .gie_clr, .sp_cpu_we, .stack_ptr, .flags, .status);
`default_nettype wire

//--- dv/ccr_cpu_model.sv
// Execution model giving one retire pulse per instruction
`timescale 1ns/1ps
`default_nettype none
module ccr_cpu_model
(
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic arst_n,
	// Bench control
	input  wire logic issue,
	input  wire logic slow,
	// Execution side
	output logic      instr_retired
);
	logic ph_r;
	// Slow mode retires every second cycle only
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			ph_r <= 1'b0;
		else
			ph_r <= !ph_r;
	end
	assign instr_retired = issue && (!slow || ph_r);
endmodule
`default_nettype wire

//--- dv/ccr_top_test.sv
// Self-checking bench of the control register bank
`timescale 1ns/1ps
`default_nettype none
module ccr_top_test
	import ccr_pkg::*;
;
	logic           sys_clk = 1'b0, arst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
	logic [5:0]     avs_address = 6'h0;
	logic [31:0]    avs_writedata = 32'h0, avs_readdata, rs = 32'h25;
	logic [3:0]     avs_byteenable = 4'h1;
	logic           avs_waitrequest, instr_retired, issue = 1'b0, slow = 1'b0;
	logic [7:0]     ev = 8'h0, flags;
	ccr_alu_flags_t alu_flags = 5'h0;
	logic           bit_store_val = 1'b0;
	logic [15:0]    sp_cpu_val = 16'h0, stack_ptr;
	ccr_status_t    status;
	logic [31:0]    expq[$];
	int             errors = 0, checks_done = 0;
	ccr_top dut (.sys_clk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .instr_retired, .mem_write(ev[6]),
		.nvm_access(ev[5]), .sleep_exec(ev[4]), .gie_set(ev[3]), .gie_clr(ev[2]), .alu_we(ev[1]),
		.alu_flags, .bit_store_we(ev[0]), .bit_store_val, .sp_cpu_we(ev[7]), .sp_cpu_val,
		.stack_ptr, .flags, .status);
	ccr_cpu_model u_cpu (.sys_clk, .arst_n, .issue, .slow, .instr_retired);
	always #12.5 sys_clk = !sys_clk;
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Request held until waitrequest is seen low at an edge
	task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d, input logic [3:0] b);
		logic [31:0] r;
		r = rnd();
		@(posedge sys_clk);
		avs_read <= !w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= {r[31:8], d};
		avs_byteenable <= b;
		@(posedge sys_clk);
		while (avs_waitrequest)
			@(posedge sys_clk);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		bus(1'b1, a, d, 4'h1);
	endtask
	task automatic rd(input logic [5:0] a, input logic [7:0] e);
		expq.push_back({24'h0, e});
		bus(1'b0, a, 8'h0, 4'h1);
	endtask
	task automatic pulse(input logic [7:0] v);
		@(posedge sys_clk);
		ev <= v;
		{alu_flags, bit_store_val} <= 6'(rnd());
		sp_cpu_val <= 16'(rnd());
		@(posedge sys_clk);
		ev <= 8'h0;
		@(negedge sys_clk);
	endtask
	task automatic retire(input int n);
		@(posedge sys_clk);
		issue <= 1'b1;
		while (n > 0)
		begin
			@(posedge sys_clk);
			if (instr_retired)
				n--;
		end
		issue <= 1'b0;
	endtask
	task automatic irq(input logic e);
		repeat (2) @(negedge sys_clk);
		cmp(status.irq_allow, e);
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Oldest expected read value against each answered read
	always @(posedge sys_clk)
		if (avs_read && !avs_waitrequest)
			cmp(avs_readdata, expq.pop_front());
	initial
	begin
		repeat (5000) @(posedge sys_clk);
		errors++;
		complete_run();
	end
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial
	begin
		logic [15:0] v;
		logic [7:0]  k;
		repeat (4) @(posedge sys_clk);
		arst_n <= 1'b1;
		rd(6'h10, CCR_GUARD_RESET);
		rd(6'h34, CCR_SRAM_TOP[7:0]);
		rd(6'h38, CCR_SRAM_TOP[15:8]);
		rd(6'h20, 8'h00);
		rd(6'h11, 8'h00);
		wr(6'h3c, 8'h80);
		irq(1'b1);
		bus(1'b1, 6'h3c, 8'h00, 4'he);
		rd(6'h3c, 8'h80);
		for (int i = 0; i < 3; i++)
		begin
			k = i == 0 ? CCR_IO_UNLOCK_KEY : i == 1 ? CCR_SELF_PROGRAM_KEY : 8'(rnd());
			v = {14'h0, k == CCR_SELF_PROGRAM_KEY, k == CCR_IO_UNLOCK_KEY};
			slow <= i[0];
			wr(6'h10, k);
			rd(6'h10, v[7:0]);
			irq(v == 16'h0);
			retire(3);
			rd(6'h10, v[7:0]);
			retire(1);
			rd(6'h10, 8'h00);
			irq(1'b1);
		end
		for (int i = 0; i < 4; i++)
		begin
			wr(6'h10, i < 2 ? CCR_IO_UNLOCK_KEY : CCR_SELF_PROGRAM_KEY);
			pulse(i == 0 ? 8'h40 : i == 1 ? 8'h20 : i == 2 ? 8'h10 : 8'h40);
			rd(6'h10, i == 3 ? 8'h02 : 8'h00);
		end
		retire(4);
		v = 16'(rnd());
		wr(6'h34, v[7:0]);
		@(negedge sys_clk);
		cmp(stack_ptr, CCR_SRAM_TOP);
		retire(3);
		irq(1'b0);
		retire(1);
		irq(1'b1);
		wr(6'h38, v[15:8]);
		@(negedge sys_clk);
		cmp(stack_ptr, v);
		rd(6'h34, v[7:0]);
		pulse(8'h80);
		rd(6'h38, v[15:8]);
		for (int i = 0; i < 4; i++)
		begin
			pulse(8'h03);
			cmp(flags, {1'b1, bit_store_val, alu_flags.h, alu_flags.n ^ alu_flags.v,
				alu_flags.v, alu_flags.n, alu_flags.z, alu_flags.c});
		end
		pulse(8'h0c);
		cmp(flags[7], 1'b0);
		irq(1'b0);
		pulse(8'h08);
		cmp(flags[7], 1'b1);
		wr(6'h3c, 8'h10);
		rd(6'h3c, 8'h00);
		wr(6'h3c, 8'h8c);
		rd(6'h3c, 8'h8c);
		@(negedge sys_clk);
		complete_run();
	end
endmodule
`default_nettype wire
